// File: include/ioport_pkg.sv
// shared constants and types for the i/o port ethernet buffering block
package ioport_pkg;
  // ---------------------------------------------------------------
  // host i/o window
  // ---------------------------------------------------------------
  localparam int IO_ADDR_W = 5;
  localparam logic [4:0] OFS_DATA = 5'h10; // data latch port
  localparam logic [4:0] OFS_RESET = 5'h18; // hardware reset port
  localparam logic [4:0] OFS_CMD = 5'h00; // command: bit0 start transmit
  localparam logic [4:0] OFS_RADDR_LO = 5'h08; // remote address low
  localparam logic [4:0] OFS_RADDR_HI = 5'h09; // remote address high
  localparam logic [4:0] OFS_RDIR = 5'h0A; // bit0 1=remote read 0=remote write
  localparam logic [4:0] OFS_TLEN_LO = 5'h05; // transmit length low
  localparam logic [4:0] OFS_TLEN_HI = 5'h06; // transmit length high
  localparam logic [4:0] OFS_TSTART = 5'h04; // transmit start page (x256)
  localparam logic [4:0] OFS_CFG = 5'h0B; // configuration byte
  localparam logic [4:0] OFS_STAT = 5'h07; // status: bit0 rx done, bit1 tx done
  // ---------------------------------------------------------------
  // configuration fields and reset values
  // ---------------------------------------------------------------
  localparam int CFG_BUS_MODE_BIT = 7; // 0 i/o port, 1 shared ram
  localparam int CFG_FAST_READ_BIT = 6;
  localparam logic [7:0] CFG_RESET = 8'h00;
  // ---------------------------------------------------------------
  // memory and link
  // ---------------------------------------------------------------
  localparam int MEM_AW = 14;
  localparam logic [13:0] PROM_BASE = 14'h0000; // station address image window
  localparam logic [13:0] PROM_LAST = 14'h001F;
  localparam logic [13:0] RX_BASE = 14'h2000;
  localparam int FIFO_DEPTH = 16;
  localparam logic [4:0] TX_THRESH = 5'h08; // refill when level falls to this
  localparam logic [4:0] RX_THRESH = 5'h08; // flush when level reaches this
  localparam logic [5:0] PREAMBLE_BYTES = 6'h07;
  localparam logic [7:0] PREAMBLE_BYTE = 8'h55;
  localparam logic [7:0] SFD_BYTE = 8'hD5;
  localparam logic [31:0] CRC_POLY = 32'hEDB88320; // reflected 802.3 polynomial
  localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
  localparam logic [3:0] MAX_ATTEMPTS = 4'hF;
  localparam logic [9:0] SLOT_CYCLES = 10'h200; // one backoff slot in bit times
  localparam logic [1:0] FAST_READ_WAIT = 2'h0;
  localparam logic [1:0] NORMAL_READ_WAIT = 2'h2;
  localparam logic [47:0] STATION_ADDR_DEFAULT = 48'h020000000001; // arbitrary value

  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_PREFETCH = 3'b001,
    TX_PREAMBLE = 3'b011,
    TX_DATA = 3'b010,
    TX_CRC = 3'b110,
    TX_BACKOFF = 3'b111
  } tx_state_t;
endpackage : ioport_pkg

// File: include/ioport_if.sv
// interface between host end and device end
`timescale 1ns/100ps
`default_nettype none
interface ioport_if;
  logic [4:0] addr; // offset in the 16+ byte i/o window
  logic ior; // host read strobe, active high here
  logic iow; // host write strobe
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic ready; // low inserts wait states
  logic irq; // receive complete interrupt
  modport device (input addr, input ior, input iow, input wdata, output rdata, output ready, output irq);
  modport host (output addr, output ior, output iow, output wdata, input rdata, input ready, input irq);
endinterface : ioport_if
`default_nettype wire

// File: core/ioport_device.sv
// device end: i/o port bus interface, remote dma latch, local dma, mac transmit and receive
//
// Summary of operation
// - host reaches buffer ram only via remote dma
// - remote dma data passes a data latch
// - remote read fetches ram byte into latch
// - wait states until latch holds read data
// - remote write stores latch byte in ram
// - reset port at base plus 18h
// - registers latch and reset decode together
// - station address obtained through remote read
// - station address image held internally
// - host loads frame, programs dma, commands
// - host pads short frames to 64 bytes
// - transmit prefetches fifo before serial output
// - preamble sent as nrz to codec
// - fifo bytes serialized after sfd
// - refill fifo at low threshold
// - crc appended as four bytes
// - collision runs backoff then retries, giving up at the 16th collision
// - receive fifo flushed to ram at threshold
// - four-byte status then host interrupt
// - config d7 selects bus mode
// - config d6 enables fast remote read
`timescale 1ns/100ps
`default_nettype none
module ioport_device
  import ioport_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic CE,
  ioport_if.device BUS,
  output logic TXD, // nrz transmit bit to the manchester_codec
  output logic TXEN,
  input wire logic COL, // collision from codec, asynchronous
  input wire logic RXD, // recovered nrz bit, already clocked by core
  input wire logic RXDV,
  output logic BUS_MODE_SELECT,
  output logic FAST_REMOTE_READ_ENABLE
);
  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [7:0] ram [0:(1<<MEM_AW)-1];
  logic [7:0] txf [0:FIFO_DEPTH-1];
  logic [7:0] cfg, tstart;
  logic tx_done, rx_done;
  // status byte seen by the host: bit0 receive done, bit1 transmit done
  wire [7:0] cmd_stat = {6'h00, tx_done, rx_done};
  logic [13:0] raddr;
  logic rdir;
  logic [15:0] tlen;
  logic [7:0] latch;
  logic latch_full;
  logic [1:0] wcnt;
  logic irq;
  logic [1:0] col_s;
  // ---------------------------------------------------------------
  // host decode
  // ---------------------------------------------------------------
  // shared window
  wire in_window = (BUS.addr[4] == 1'b0) || (BUS.addr == OFS_DATA) || (BUS.addr == OFS_RESET);
  wire data_acc = (BUS.addr == OFS_DATA);
  wire soft_rst = (BUS.ior || BUS.iow) && (BUS.addr == OFS_RESET);
  wire rst = RST || soft_rst;
  wire [13:0] prom_ofs = raddr - PROM_BASE;
  wire [7:0] prom_byte = STATION_ADDR_DEFAULT[8'(47 - 8*prom_ofs[2:0]) -: 8];
  wire in_prom = (raddr <= PROM_LAST);
  wire [7:0] fetch = in_prom ? (prom_ofs < 14'h6 ? prom_byte : 8'h00) : ram[raddr];
  wire [1:0] wait_need = cfg[CFG_FAST_READ_BIT] ? FAST_READ_WAIT : NORMAL_READ_WAIT;
  assign BUS.ready = !(BUS.ior && data_acc && !(latch_full && wcnt >= wait_need));
  assign BUS.rdata = data_acc ? latch : (BUS.addr == OFS_STAT ? cmd_stat : (BUS.addr == OFS_CFG ? cfg : 8'h00));
  assign BUS.irq = irq;
  assign BUS_MODE_SELECT = cfg[CFG_BUS_MODE_BIT];
  assign FAST_REMOTE_READ_ENABLE = cfg[CFG_FAST_READ_BIT];
  logic ior_d;
  wire ior_end = ior_d && !BUS.ior;
  // ---------------------------------------------------------------
  // transmit state and datapath
  // ---------------------------------------------------------------
  tx_state_t st;
  logic [13:0] tptr;
  logic [15:0] tleft, fleft;
  logic [3:0] wp, rp;
  logic [4:0] lvl;
  logic [7:0] sh;
  logic [2:0] bitn;
  logic [5:0] pcnt;
  logic [1:0] ccnt;
  logic [31:0] crc, lfsr;
  logic [3:0] att;
  logic [19:0] bo;
  wire col = col_s[1];
  wire fetch_ok = (fleft != 16'h0) && (lvl < 5'(FIFO_DEPTH));
  wire [31:0] crc_n = (crc >> 1) ^ (((crc[0] ^ sh[0]) != 1'b0) ? CRC_POLY : 32'h0);
  wire [31:0] crc_out = ~crc;
  // ---------------------------------------------------------------
  // receive
  // ---------------------------------------------------------------
  logic [7:0] rsh, rxq [0:FIFO_DEPTH-1];
  logic [2:0] rbit;
  logic [3:0] rwp, rrp;
  logic [4:0] rlvl;
  logic rxdv_d, rx_flush;
  logic [13:0] rptr, rstart;
  logic [15:0] rcount;
  logic [2:0] sidx;
  wire rx_push = RXDV && (rbit == 3'h7);

  always_ff @(posedge CLOCK)
  begin
    if (rst)
    begin
      col_s <= 2'h0;
    end
    else if (CE)
    begin
      col_s <= {col_s[0], COL};
    end
  end

  // host register writes and remote dma latch
  always_ff @(posedge CLOCK)
  begin
    if (rst)
    begin
      cfg <= CFG_RESET;
      raddr <= 14'h0;
      rdir <= 1'b0;
      tlen <= 16'h0;
      tstart <= 8'h0;
      latch <= 8'h0;
      latch_full <= 1'b0;
      wcnt <= 2'h0;
      ior_d <= 1'b0;
    end
    else if (CE)
    begin
      ior_d <= BUS.ior && data_acc;
      if (BUS.iow && in_window && !data_acc)
      begin
        if (BUS.addr == OFS_RADDR_LO) raddr[7:0] <= BUS.wdata;
        else if (BUS.addr == OFS_RADDR_HI) raddr[13:8] <= BUS.wdata[5:0];
        else if (BUS.addr == OFS_RDIR) rdir <= BUS.wdata[0];
        else if (BUS.addr == OFS_TLEN_LO) tlen[7:0] <= BUS.wdata;
        else if (BUS.addr == OFS_TLEN_HI) tlen[15:8] <= BUS.wdata;
        else if (BUS.addr == OFS_TSTART) tstart <= BUS.wdata;
        else if (BUS.addr == OFS_CFG) cfg <= BUS.wdata;
      end
      if (rdir && !latch_full && !ior_end)
      begin
        latch <= fetch;
        latch_full <= 1'b1;
        wcnt <= 2'h0;
      end
      else if (rdir && ior_end)
      begin
        latch_full <= 1'b0;
        raddr <= raddr + 14'h1;
      end
      else if (latch_full && wcnt != 2'h3)
      begin
        wcnt <= wcnt + 2'h1;
      end
      if (!rdir && BUS.iow && data_acc)
      begin
        latch <= BUS.wdata;
        latch_full <= 1'b1;
      end
      else if (!rdir && latch_full)
      begin
        latch_full <= 1'b0;
        raddr <= raddr + 14'h1;
      end
      if (BUS.iow && BUS.addr == OFS_RDIR)
      begin
        latch_full <= 1'b0;
      end
    end
  end

  // buffer ram writers: remote write, receive flush, status record
  always_ff @(posedge CLOCK)
  begin
    if (CE)
    begin
      if (!rdir && latch_full && !in_prom)
      begin
        ram[raddr] <= latch;
      end
      else if (rx_flush)
      begin
        ram[rptr] <= rxq[rrp];
      end
      else if (sidx != 3'h0)
      begin
        ram[rstart + 14'(sidx) - 14'h1] <= (sidx == 3'h1) ? 8'h01 : (sidx == 3'h3) ? rcount[7:0] :
          (sidx == 3'h4) ? rcount[15:8] : 8'h00;
      end
    end
  end

  // transmit machine
  always_ff @(posedge CLOCK)
  begin
    if (rst)
    begin
      st <= TX_IDLE;
      {tptr, tleft, fleft, wp, rp, lvl, sh, bitn, pcnt, ccnt, att, bo} <= '0;
      crc <= CRC_INIT;
      lfsr <= 32'h1;
      TXD <= 1'b0;
      TXEN <= 1'b0;
      tx_done <= 1'b0;
    end
    else if (CE)
    begin
      lfsr <= {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      if (BUS.ior && BUS.addr == OFS_STAT) tx_done <= 1'b0;
      if (st != TX_IDLE && st != TX_BACKOFF && fetch_ok && (st == TX_PREFETCH || lvl <= TX_THRESH))
      begin
        txf[wp] <= ram[tptr];
        wp <= wp + 4'h1;
        tptr <= tptr + 14'h1;
        fleft <= fleft - 16'h1;
      end
      lvl <= lvl + 5'(st != TX_IDLE && st != TX_BACKOFF && fetch_ok && (st == TX_PREFETCH || lvl <= TX_THRESH))
        - 5'(st == TX_DATA && bitn == 3'h7 && tleft != 16'h1);
      case (st)
        TX_IDLE:
        begin
          // enable falls one clock after the last check bit
          TXEN <= 1'b0;
          if (BUS.iow && BUS.addr == OFS_CMD && BUS.wdata[0])
          begin
            {wp, rp, lvl} <= '0;
            tptr <= {tstart[5:0], 8'h00};
            fleft <= tlen;
            tleft <= tlen;
            att <= 4'h0;
            st <= TX_PREFETCH;
          end
        end
        TX_PREFETCH:
        begin
          if (lvl == 5'(FIFO_DEPTH) || fleft == 16'h0)
          begin
            st <= TX_PREAMBLE;
            pcnt <= 6'h0;
            bitn <= 3'h0;
            sh <= PREAMBLE_BYTE;
          end
        end
        TX_PREAMBLE:
        begin
          TXEN <= 1'b1; // enable rises with the first bit
          TXD <= sh[bitn];
          bitn <= bitn + 3'h1;
          if (bitn == 3'h7)
          begin
            pcnt <= pcnt + 6'h1;
            sh <= (pcnt + 6'h1 == PREAMBLE_BYTES) ? SFD_BYTE : PREAMBLE_BYTE;
            if (pcnt == PREAMBLE_BYTES)
            begin
              st <= TX_DATA;
              sh <= txf[rp];
              crc <= CRC_INIT;
            end
          end
        end
        TX_DATA:
        begin
          TXD <= sh[0];
          crc <= crc_n;
          sh <= {1'b0, sh[7:1]};
          bitn <= bitn + 3'h1;
          if (bitn == 3'h7)
          begin
            tleft <= tleft - 16'h1;
            rp <= rp + 4'h1;
            sh <= txf[rp + 4'h1];
            if (tleft == 16'h1)
            begin
              st <= TX_CRC;
              ccnt <= 2'h0;
            end
          end
        end
        TX_CRC:
        begin
          TXD <= crc_out[{ccnt, bitn}];
          bitn <= bitn + 3'h1;
          if (bitn == 3'h7)
          begin
            ccnt <= ccnt + 2'h1;
            if (ccnt == 2'h3)
            begin
              st <= TX_IDLE;
              tx_done <= 1'b1;
            end
          end
        end
        TX_BACKOFF:
        begin
          bo <= bo - 20'h1;
          if (bo == 20'h0)
          begin
            tptr <= {tstart[5:0], 8'h00};
            fleft <= tlen;
            tleft <= tlen;
            {wp, rp, lvl} <= '0;
            st <= TX_PREFETCH;
          end
        end
        default: st <= TX_IDLE;
      endcase
      if (col && (st == TX_PREAMBLE || st == TX_DATA || st == TX_CRC))
      begin
        TXEN <= 1'b0;
        att <= att + 4'h1;
        st <= (att == MAX_ATTEMPTS) ? TX_IDLE : TX_BACKOFF;
        bo <= 20'(lfsr[9:0] & 10'((11'h2 << (att > 4'h9 ? 4'h9 : att)) - 11'h1)) * 20'(SLOT_CYCLES);
      end
    end
  end

  // receive deserializer, fifo flush, status and interrupt
  always_ff @(posedge CLOCK)
  begin
    if (rst)
    begin
      {rsh, rbit, rwp, rrp, rlvl, rxdv_d, rx_flush, rcount, sidx} <= '0;
      rptr <= RX_BASE + 14'h4;
      rstart <= RX_BASE;
      irq <= 1'b0;
      rx_done <= 1'b0;
    end
    else if (CE)
    begin
      rxdv_d <= RXDV;
      if (RXDV)
      begin
        rsh <= {RXD, rsh[7:1]};
        rbit <= rbit + 3'h1;
      end
      if (rx_push)
      begin
        rxq[rwp] <= {RXD, rsh[7:1]};
        rwp <= rwp + 4'h1;
        rcount <= rcount + 16'h1;
      end
      rx_flush <= (rlvl >= RX_THRESH) || (!RXDV && rlvl != 5'h0 && !rx_flush);
      if (rx_flush)
      begin
        rrp <= rrp + 4'h1;
        rptr <= rptr + 14'h1;
      end
      rlvl <= rlvl + 5'(rx_push) - 5'(rx_flush);
      // host clear, overridden below by a set in the same cycle
      if (BUS.iow && BUS.addr == OFS_STAT && BUS.wdata[0])
      begin
        irq <= 1'b0;
        rx_done <= 1'b0;
      end
      if (rxdv_d && !RXDV)
      begin
        sidx <= 3'h1;
        rbit <= 3'h0;
      end
      else if (sidx != 3'h0 && !rx_flush && rlvl == 5'h0)
      begin
        sidx <= (sidx == 3'h4) ? 3'h0 : sidx + 3'h1;
        if (sidx == 3'h4)
        begin
          irq <= 1'b1;
          rx_done <= 1'b1;
          rstart <= rptr;
          rptr <= rptr + 14'h4;
          rcount <= 16'h0;
        end
      end
    end
  end
endmodule : ioport_device
`default_nettype wire

// File: core/ioport_host.sv
// host end: drives i/o cycles on the device's port from a simple user request
`timescale 1ns/100ps
`default_nettype none
module ioport_host
  import ioport_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic CE,
  ioport_if.host BUS,
  input wire logic REQ_VALID, // one i/o cycle request
  input wire logic REQ_WRITE,
  input wire logic [4:0] REQ_ADDR,
  input wire logic [7:0] REQ_DATA,
  output logic REQ_READY,
  output logic RSP_VALID,
  output logic [7:0] RSP_DATA,
  output logic IRQ
);
  // ---------------------------------------------------------------
  // one cycle at a time; are kept by the driver issuing requests
  // ---------------------------------------------------------------
  logic busy, wr;
  logic [4:0] a;
  logic [7:0] d;
  assign BUS.addr = a;
  assign BUS.wdata = d;
  assign BUS.ior = busy && !wr;
  assign BUS.iow = busy && wr;
  assign REQ_READY = !busy;
  assign IRQ = BUS.irq;

  // strobe held until device ready; host side of the cycle
  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      {busy, wr, a, d, RSP_VALID, RSP_DATA} <= '0;
    end
    else if (CE)
    begin
      RSP_VALID <= 1'b0;
      if (!busy && REQ_VALID)
      begin
        busy <= 1'b1;
        wr <= REQ_WRITE;
        a <= REQ_ADDR;
        d <= REQ_DATA;
      end
      else if (busy && BUS.ready)
      begin
        busy <= 1'b0;
        RSP_VALID <= !wr;
        RSP_DATA <= BUS.rdata;
      end
    end
  end
endmodule : ioport_host
`default_nettype wire

// File: tb/ioport_assertions.sv
// concurrent checks on the host-device i/o port signals
`timescale 1ns/100ps
`default_nettype none
module ioport_assertions
  import ioport_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic [4:0] addr,
  input wire logic ior,
  input wire logic iow,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic ready,
  input wire logic irq
);
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (RST);
  // ---------------------------------------------------------------
  // strobes, wait states and interrupt
  // ---------------------------------------------------------------
  property p_one_strobe;
    !(ior && iow);
  endproperty
  a_one_strobe: assert property (p_one_strobe) else $error("both strobes active");
  property p_ready_idle;
    !ior && !iow |-> ready;
  endproperty
  a_ready_idle: assert property (p_ready_idle) else $error("wait state without a cycle");
  property p_hold;
    (ior || iow) && !ready |=> $stable(addr) && $stable(ior) && $stable(iow);
  endproperty
  a_hold: assert property (p_hold) else $error("cycle changed during wait");
  property p_wait_bound;
    $rose(ior) |-> ##[0:40] ready;
  endproperty
  a_wait_bound: assert property (p_wait_bound) else $error("read never completed");
  property p_strobe_ends;
    (ior || iow) && ready |=> !ior && !iow;
  endproperty
  a_strobe_ends: assert property (p_strobe_ends) else $error("strobe held after ready");
  property p_wdata_hold;
    iow && !ready |=> $stable(wdata);
  endproperty
  a_wdata_hold: assert property (p_wdata_hold) else $error("write data moved");
  property p_irq_hold;
    irq && !(ior || iow) && !$past(ior || iow) |=> irq;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped by itself");
  property p_reset_port;
    (ior || iow) && ready && addr == OFS_RESET |=> ##[0:2] !irq;
  endproperty
  a_reset_port: assert property (p_reset_port) else $error("reset port left interrupt");
  c_wait: cover property ($rose(ior) ##1 !ready);
  c_irq: cover property ($rose(irq));
  c_write: cover property (iow && ready && addr == OFS_DATA);
endmodule : ioport_assertions
`default_nettype wire

// File: tb/tb_top.sv
// self-checking bench: host and device ends joined through the i/o port
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import ioport_pkg::*;
;
  typedef struct {logic w; logic [4:0] a; logic [7:0] d; logic [7:0] e;} row_t;
  localparam logic W = 1'b1;
  localparam logic R = 1'b0;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [4:0] req_addr = 5'h00;
  logic [7:0] req_data = 8'h00;
  logic col = 1'b0;
  logic rxd = 1'b0;
  logic rxdv = 1'b0;
  logic req_ready, rsp_valid, txd, txen, bus_mode, fast_read, irq;
  logic [7:0] rsp_data, q, e;
  logic [127:0] bits;
  logic [31:0] crc;
  logic [7:0] frame [4] = '{8'hA1, 8'hB2, 8'hC3, 8'hD4};
  int n;
  int fail_count = 0;
  int compares = 0;
  // station image, prom write attempt, remote write then read back
  row_t rows[$] = '{'{W, OFS_CFG, 8'h40, 8'h00}, '{W, OFS_RADDR_LO, 8'h00, 8'h00},
    '{W, OFS_RADDR_HI, 8'h00, 8'h00}, '{W, OFS_DATA, 8'hFF, 8'h00}, '{W, OFS_RADDR_LO, 8'h00, 8'h00},
    '{W, OFS_RADDR_HI, 8'h01, 8'h00}, '{W, OFS_DATA, 8'hA1, 8'h00}, '{W, OFS_DATA, 8'hB2, 8'h00},
    '{W, OFS_DATA, 8'hC3, 8'h00}, '{W, OFS_DATA, 8'hD4, 8'h00}, '{W, OFS_RADDR_LO, 8'h00, 8'h00},
    '{W, OFS_RADDR_HI, 8'h00, 8'h00}, '{W, OFS_RDIR, 8'h01, 8'h00},
    '{R, OFS_DATA, 8'h00, STATION_ADDR_DEFAULT[47:40]}, '{R, OFS_DATA, 8'h00, STATION_ADDR_DEFAULT[39:32]},
    '{R, OFS_DATA, 8'h00, STATION_ADDR_DEFAULT[31:24]}, '{R, OFS_DATA, 8'h00, STATION_ADDR_DEFAULT[23:16]},
    '{R, OFS_DATA, 8'h00, STATION_ADDR_DEFAULT[15:8]}, '{R, OFS_DATA, 8'h00, STATION_ADDR_DEFAULT[7:0]},
    '{R, OFS_DATA, 8'h00, 8'h00}, '{W, OFS_RDIR, 8'h00, 8'h00}, '{W, OFS_CFG, 8'h00, 8'h00},
    '{W, OFS_RADDR_LO, 8'h00, 8'h00}, '{W, OFS_RADDR_HI, 8'h01, 8'h00}, '{W, OFS_RDIR, 8'h01, 8'h00},
    '{R, OFS_DATA, 8'h00, 8'hA1}, '{R, OFS_DATA, 8'h00, 8'hB2}, '{R, OFS_DATA, 8'h00, 8'hC3},
    '{R, OFS_DATA, 8'h00, 8'hD4}, '{W, OFS_RDIR, 8'h00, 8'h00}};
  ioport_if bus ();
  ioport_device ioport_device_inst (.CLOCK(clk), .RST(rst), .CE(1'b1), .BUS(bus.device), .TXD(txd),
    .TXEN(txen), .COL(col), .RXD(rxd), .RXDV(rxdv), .BUS_MODE_SELECT(bus_mode), .FAST_REMOTE_READ_ENABLE(fast_read));
  ioport_host ioport_host_inst (.CLOCK(clk), .RST(rst), .CE(1'b1), .BUS(bus.host), .REQ_VALID(req_valid),
    .REQ_WRITE(req_write), .REQ_ADDR(req_addr), .REQ_DATA(req_data), .REQ_READY(req_ready),
    .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data), .IRQ(irq));
  ioport_assertions ioport_assertions_inst (.CLOCK(clk), .RST(rst), .addr(bus.addr), .ior(bus.ior),
    .iow(bus.iow), .wdata(bus.wdata), .rdata(bus.rdata), .ready(bus.ready), .irq(bus.irq));
  // free-running core clock
  always #4 clk = ~clk;
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk8
  task automatic chk1(input logic got, input logic exp, input string what);
    chk8({7'h00, got}, {7'h00, exp}, what);
  endtask : chk1
  // one host cycle through the user request port
  task automatic io(input logic w, input logic [4:0] a, input logic [7:0] d, output logic [7:0] r);
    @(posedge clk);
    #1;
    req_valid = 1'b1;
    req_write = w;
    req_addr = a;
    req_data = d;
    n = 0;
    do @(negedge clk); while (req_ready !== 1'b1 && ++n < 100);
    @(posedge clk);
    #1;
    req_valid = 1'b0;
    n = 0;
    if (w)
      do @(negedge clk); while (!(bus.iow === 1'b1 && bus.ready === 1'b1) && ++n < 100);
    else
      do @(negedge clk); while (rsp_valid !== 1'b1 && ++n < 100);
    r = rsp_data;
    chk1(n < 100, 1'b1, "host cycle finished");
  endtask : io
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] r;
    io(W, a, d, r);
  endtask : wr
  // reference frame check over the four payload bytes
  function automatic logic [31:0] fcs();
    logic [31:0] c;
    c = CRC_INIT;
    for (int i = 0; i < 32; i++)
      c = (c[0] ^ frame[i / 8][i % 8]) ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    return ~c;
  endfunction : fcs
  task automatic stop_test;
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : stop_test
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    repeat (8) @(posedge clk);
    #1;
    rst = 1'b0;
    chk1(bus_mode, 1'b0, "bus mode after reset");
    chk1(fast_read, 1'b0, "fast read after reset");
    foreach (rows[i])
    begin
      io(rows[i].w, rows[i].a, rows[i].d, q);
      if (rows[i].w === R)
        chk8(q, rows[i].e, "remote read byte");
    end
    // transmit with one collision, then the retried frame
    wr(OFS_TSTART, 8'h01);
    wr(OFS_TLEN_LO, 8'h04);
    wr(OFS_TLEN_HI, 8'h00);
    wr(OFS_CMD, 8'h01);
    n = 0;
    do @(negedge clk); while (txen !== 1'b1 && ++n < 2000);
    repeat (10) @(posedge clk);
    #1;
    col = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    col = 1'b0;
    n = 0;
    do @(negedge clk); while (txen !== 1'b0 && ++n < 200);
    chk1(txen, 1'b0, "transmit stops on collision");
    n = 0;
    do @(negedge clk); while (txen !== 1'b1 && ++n < 3000);
    chk1(txen, 1'b1, "transmit retried");
    for (int b = 0; b < 128; b++)
    begin
      bits[b] = txd;
      @(negedge clk);
    end
    chk1(txen, 1'b0, "enable drops after check bytes");
    crc = fcs();
    for (int k = 0; k < 16; k++)
    begin
      e = (k < 7) ? PREAMBLE_BYTE : (k == 7) ? SFD_BYTE : (k < 12) ? frame[k - 8] : crc[8 * (k - 12) +: 8];
      chk8(bits[8 * k +: 8], e, "serial byte");
    end
    io(R, OFS_STAT, 8'h00, q);
    chk1(q[1], 1'b1, "transmit done flag");
    // receive eight bytes, then status record and interrupt
    for (int k = 0; k < 64; k++)
    begin
      @(posedge clk);
      #1;
      e = 8'h30 + 8'(k / 8);
      rxdv = 1'b1;
      rxd = e[k % 8];
    end
    @(posedge clk);
    #1;
    rxdv = 1'b0;
    n = 0;
    do @(negedge clk); while (irq !== 1'b1 && ++n < 500);
    chk1(irq, 1'b1, "receive interrupt");
    io(R, OFS_STAT, 8'h00, q);
    chk1(q[0], 1'b1, "receive done flag");
    wr(OFS_RADDR_LO, 8'h00);
    wr(OFS_RADDR_HI, 8'h20);
    wr(OFS_RDIR, 8'h01);
    for (int k = 0; k < 12; k++)
    begin
      io(R, OFS_DATA, 8'h00, q);
      e = (k == 0) ? 8'h01 : (k == 2) ? 8'h08 : (k < 4) ? 8'h00 : 8'h30 + 8'(k - 4);
      chk8(q, e, "receive buffer byte");
    end
    wr(OFS_RDIR, 8'h00);
    wr(OFS_STAT, 8'h01);
    @(negedge clk);
    chk1(irq, 1'b0, "interrupt cleared");
    // configuration pins, then the reset port
    wr(OFS_CFG, 8'hC0);
    @(negedge clk);
    chk1(bus_mode, 1'b1, "bus mode pin");
    chk1(fast_read, 1'b1, "fast read pin");
    wr(OFS_RESET, 8'h00);
    repeat (3) @(negedge clk);
    chk1(bus_mode, 1'b0, "reset port clears config");
    stop_test();
  end
  // watchdog against a hung handshake
  initial
  begin
    #(8 * 40000);
    fail_count++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
